// ===== hdl/fbm_host.sv
// Functional notes
// - buffered program holds at most 16 words
// - accelerated program uses two-cycle sequence
// - high voltage only during accelerated programming
// - host flags operation interrupted by reset for redo on restart_o
// - read: select and gate low, strobe high
// - write: strobe and select low, gate high
module fbm_host #(
	parameter logic [15:0] UNLOCK1_ADDR = 16'h0001, // arbitrary
	parameter logic [15:0] UNLOCK1_DATA = 16'h0001, // arbitrary
	parameter logic [15:0] UNLOCK2_ADDR = 16'h0002, // arbitrary
	parameter logic [15:0] UNLOCK2_DATA = 16'h0002, // arbitrary
	parameter logic [15:0] PROG_CMD = 16'h0003, // arbitrary
	parameter logic [15:0] ID_CMD = 16'h0004, // arbitrary
	parameter logic [15:0] BUF_LOAD_CMD = 16'h0005, // arbitrary
	parameter logic [15:0] BUF_CONFIRM_CMD = 16'h0006 // arbitrary
) (
	input wire logic clk_i, // 10 MHz clock
	input wire logic nrst_i, // sync reset, active low
	input wire fbm_pkg::fbm_cmd_t cmd_i, // user request
	input wire logic cmd_valid_i, // request valid
	input wire logic accel_req_i, // use accelerated programming
	input wire logic protect_i, // force hardware protection
	input wire logic busy_i, // device ready/busy, high = busy
	input wire logic [fbm_pkg::DATA_W-1:0] dq_i, // data pins in
	output logic cmd_ready_o, // idle, request accepted
	output logic done_o, // request finished pulse
	output logic err_o, // request refused pulse
	output logic [fbm_pkg::DATA_W-1:0] rd_data_o, // read result
	output logic id_mode_o, // device in identification mode
	output logic restart_o, // interrupted program needs redo
	output logic [fbm_pkg::SECT_W-1:0] sector_o, // last sector addressed
	output fbm_pkg::fbm_pins_t pins_o // flash control pins
);
	import fbm_pkg::*;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_RD = 6'b000010,
		ST_WLO = 6'b000100,
		ST_WHI = 6'b001000,
		ST_RST = 6'b010000,
		ST_REC = 6'b100000
	} fbm_state_t;

	fbm_state_t state_ff;
	fbm_pins_t pins_ff;
	fbm_wcyc_t seq_ff [SEQ_MAX];
	logic [2:0] seq_len_ff;
	logic [2:0] seq_idx_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [4:0] buf_cnt_ff;
	logic [4:0] buf_lim_ff;
	logic [SECT_W-1:0] buf_sect_ff;
	logic id_mode_ff;
	logic restart_ff;
	logic ready_ff;
	logic done_ff;
	logic err_ff;
	logic [DATA_W-1:0] rd_data_ff;
	logic [SECT_W-1:0] sector_ff;
	logic take;
	logic refuse;
	logic [ADDR_W-1:0] sect_base;

	assign take = ready_ff && cmd_valid_i;
	assign sect_base = {cmd_i.addr[ADDR_W-1:SECT_LSB], 16'h0000};

	// buffer words beyond the declared count or beyond 16 are refused
	always_comb begin
		refuse = 1'b0;
		unique case (cmd_i.op)
			FBM_OP_BUF_BEGIN: refuse = cmd_i.data >= DATA_W'(BUF_MAX_WORDS);
			FBM_OP_BUF_WORD: refuse = buf_cnt_ff >= buf_lim_ff
				|| cmd_i.addr[ADDR_W-1:SECT_LSB] != buf_sect_ff;
			FBM_OP_BUF_CONFIRM: refuse = buf_cnt_ff != buf_lim_ff;
			default: refuse = 1'b0;
		endcase
	end

	// write-cycle list built at acceptance, then walked by the state machine
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			seq_len_ff <= 3'h0;
			for (int i = 0; i < SEQ_MAX; i++) begin
				seq_ff[i] <= '0;
			end
		end else if (take && !refuse) begin
			seq_ff[0] <= '{addr: ADDR_W'(UNLOCK1_ADDR), data: UNLOCK1_DATA};
			seq_ff[1] <= '{addr: ADDR_W'(UNLOCK2_ADDR), data: UNLOCK2_DATA};
			seq_len_ff <= 3'h4;
			unique case (cmd_i.op)
				FBM_OP_WRITE, FBM_OP_BUF_WORD: begin
					seq_ff[0] <= '{addr: cmd_i.addr, data: cmd_i.data};
					seq_len_ff <= 3'h1;
				end
				FBM_OP_BUF_CONFIRM: begin
					seq_ff[0] <= '{addr: sect_base, data: BUF_CONFIRM_CMD};
					seq_len_ff <= 3'h1;
				end
				FBM_OP_PROG: begin
					if (accel_req_i) begin
						seq_ff[0] <= '{addr: cmd_i.addr, data: PROG_CMD};
						seq_ff[1] <= '{addr: cmd_i.addr, data: cmd_i.data};
						seq_len_ff <= 3'h2;
					end else begin
						seq_ff[2] <= '{addr: ADDR_W'(UNLOCK1_ADDR), data: PROG_CMD};
						seq_ff[3] <= '{addr: cmd_i.addr, data: cmd_i.data};
					end
				end
				FBM_OP_ID_ENTER: begin
					seq_ff[2] <= '{addr: ADDR_W'(UNLOCK1_ADDR), data: ID_CMD};
					seq_len_ff <= 3'h3;
				end
				FBM_OP_BUF_BEGIN: begin
					seq_ff[2] <= '{addr: sect_base, data: BUF_LOAD_CMD};
					seq_ff[3] <= '{addr: sect_base, data: cmd_i.data};
				end
				default: seq_len_ff <= 3'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			buf_cnt_ff <= 5'h00;
			buf_lim_ff <= 5'h00;
			buf_sect_ff <= '0;
		end else if (take && !refuse) begin
			if (cmd_i.op == FBM_OP_BUF_BEGIN) begin
				buf_cnt_ff <= 5'h00;
				buf_lim_ff <= cmd_i.data[4:0] + 5'h01; // count is words minus one
				buf_sect_ff <= cmd_i.addr[ADDR_W-1:SECT_LSB];
			end else if (cmd_i.op == FBM_OP_BUF_WORD) begin
				buf_cnt_ff <= buf_cnt_ff + 5'h01;
			end else if (cmd_i.op == FBM_OP_BUF_CONFIRM || cmd_i.op == FBM_OP_RESET) begin
				buf_lim_ff <= 5'h00;
				buf_cnt_ff <= 5'h00;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state_ff <= ST_IDLE;
			cnt_ff <= '0;
			seq_idx_ff <= 3'h0;
			ready_ff <= 1'b0;
			done_ff <= 1'b0;
			err_ff <= 1'b0;
			rd_data_ff <= '0;
		end else begin
			done_ff <= 1'b0;
			err_ff <= 1'b0;
			unique case (state_ff)
				ST_IDLE: begin
					ready_ff <= 1'b1;
					if (take) begin
						ready_ff <= 1'b0;
						seq_idx_ff <= 3'h0;
						if (refuse) begin
							err_ff <= 1'b1;
							ready_ff <= 1'b1;
						end else if (cmd_i.op == FBM_OP_READ) begin
							state_ff <= ST_RD;
							cnt_ff <= CNT_W'(ACCESS_CYC);
						end else if (cmd_i.op == FBM_OP_RESET) begin
							state_ff <= ST_RST;
							cnt_ff <= CNT_W'(MIN_RESET_PULSE_CYC);
						end else begin
							// one idle-strobe phase first, so the pins of cycle 0 load from the built list
							state_ff <= ST_WHI;
							cnt_ff <= CNT_W'(WE_HIGH_CYC);
							seq_idx_ff <= 3'h7;
						end
					end
				end
				ST_RD: begin
					cnt_ff <= cnt_ff - CNT_W'(1);
					if (cnt_ff == CNT_W'(1)) begin
						// identification codes only carry the low byte
						rd_data_ff <= id_mode_ff ? (dq_i & ID_BYTE_MASK) : dq_i;
						done_ff <= 1'b1;
						ready_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end
				end
				ST_WLO: begin
					cnt_ff <= cnt_ff - CNT_W'(1);
					if (cnt_ff == CNT_W'(1)) begin
						state_ff <= ST_WHI;
						cnt_ff <= CNT_W'(WE_HIGH_CYC);
					end
				end
				ST_WHI: begin
					cnt_ff <= cnt_ff - CNT_W'(1);
					if (cnt_ff == CNT_W'(1)) begin
						if (seq_idx_ff + 3'h1 == seq_len_ff) begin
							done_ff <= 1'b1;
							ready_ff <= 1'b1;
							state_ff <= ST_IDLE;
						end else begin
							seq_idx_ff <= seq_idx_ff + 3'h1;
							state_ff <= ST_WLO;
							cnt_ff <= CNT_W'(WE_LOW_CYC);
						end
					end
				end
				ST_RST: begin
					cnt_ff <= cnt_ff - CNT_W'(1);
					if (cnt_ff == CNT_W'(1)) begin
						state_ff <= ST_REC;
						cnt_ff <= CNT_W'(RESET_RECOVER_CYC);
					end
				end
				ST_REC: begin
					cnt_ff <= cnt_ff - CNT_W'(1);
					if (cnt_ff == CNT_W'(1)) begin
						done_ff <= 1'b1;
						ready_ff <= 1'b1;
						state_ff <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// pin drive; idle leaves select and gate high so the device sits in standby
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0, wp_level: 1'b1,
				hv_en: 1'b0, addr: '0, dq_out: '0, dq_oe_n: 1'b1};
		end else begin
			pins_ff.rst_n <= 1'b1;
			pins_ff.ce_n <= 1'b1;
			pins_ff.oe_n <= 1'b1;
			pins_ff.we_n <= 1'b1;
			pins_ff.dq_oe_n <= 1'b1;
			pins_ff.wp_level <= !protect_i;
			if (state_ff == ST_IDLE && take && !refuse) begin
				// high voltage is raised only for a program in accelerated mode
				pins_ff.hv_en <= cmd_i.op == FBM_OP_PROG && accel_req_i;
			end else if (state_ff == ST_IDLE) begin
				pins_ff.hv_en <= 1'b0;
			end
			if (state_ff == ST_IDLE && take && !refuse && cmd_i.op == FBM_OP_READ) begin
				// address then held until the next request, letting sleep keep data
				pins_ff.addr <= cmd_i.addr;
				pins_ff.ce_n <= 1'b0;
				pins_ff.oe_n <= 1'b0;
			end else if (state_ff == ST_RD && cnt_ff != CNT_W'(1)) begin
				pins_ff.ce_n <= 1'b0;
				pins_ff.oe_n <= 1'b0;
			end else if ((state_ff == ST_IDLE && take && !refuse && cmd_i.op == FBM_OP_RESET)
				|| (state_ff == ST_RST && cnt_ff != CNT_W'(1))) begin
				pins_ff.rst_n <= 1'b0;
			end else if ((state_ff == ST_WLO && cnt_ff != CNT_W'(1)) || (state_ff == ST_WHI
				&& cnt_ff == CNT_W'(1) && seq_idx_ff + 3'h1 != seq_len_ff)) begin
				pins_ff.addr <= seq_ff[state_ff == ST_WLO ? seq_idx_ff[1:0] : seq_idx_ff[1:0] + 2'h1].addr;
				pins_ff.dq_out <= seq_ff[state_ff == ST_WLO ? seq_idx_ff[1:0] : seq_idx_ff[1:0] + 2'h1].data;
				pins_ff.ce_n <= 1'b0;
				pins_ff.we_n <= 1'b0;
				pins_ff.dq_oe_n <= 1'b0;
			end
		end
	end

	// identification mode, restart flag and last sector, updated at acceptance
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			id_mode_ff <= 1'b0;
			restart_ff <= 1'b0;
			sector_ff <= '0;
		end else if (take && !refuse) begin
			sector_ff <= cmd_i.addr[ADDR_W-1:SECT_LSB];
			if (cmd_i.op == FBM_OP_ID_ENTER) begin
				id_mode_ff <= 1'b1;
			end else if (cmd_i.op == FBM_OP_RESET) begin
				id_mode_ff <= 1'b0;
			end
			if (cmd_i.op == FBM_OP_RESET && busy_i) begin
				restart_ff <= 1'b1;
			end else if (cmd_i.op == FBM_OP_PROG || cmd_i.op == FBM_OP_BUF_BEGIN) begin
				restart_ff <= 1'b0;
			end
		end
	end

	assign cmd_ready_o = ready_ff;
	assign done_o = done_ff;
	assign err_o = err_ff;
	assign rd_data_o = rd_data_ff;
	assign id_mode_o = id_mode_ff;
	assign restart_o = restart_ff;
	assign sector_o = sector_ff;
	assign pins_o = pins_ff;
endmodule

// ===== hdl/fbm_pkg.sv
package fbm_pkg;
	localparam int unsigned ADDR_W = 25;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned SECT_LSB = 16;
	localparam int unsigned SECT_W = ADDR_W - SECT_LSB;
	localparam int unsigned CLK_NS = 100;
	// least times round up to whole cycles
	localparam int unsigned ACCESS_NS = 110;
	localparam int unsigned ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned WE_LOW_NS = 100;
	localparam int unsigned WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned WE_HIGH_NS = 100;
	localparam int unsigned WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned MIN_RESET_PULSE_NS = 500;
	localparam int unsigned MIN_RESET_PULSE_CYC = (MIN_RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned RESET_RECOVER_NS = 200;
	localparam int unsigned RESET_RECOVER_CYC = (RESET_RECOVER_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned BUF_MAX_WORDS = 16;
	localparam int unsigned SEQ_MAX = 4;
	localparam int unsigned CNT_W = 8;
	localparam logic [15:0] ID_BYTE_MASK = 16'h00ff;

	typedef enum logic [2:0] {
		FBM_OP_READ = 3'h0,
		FBM_OP_WRITE = 3'h1,
		FBM_OP_PROG = 3'h2,
		FBM_OP_ID_ENTER = 3'h3,
		FBM_OP_BUF_BEGIN = 3'h4,
		FBM_OP_BUF_WORD = 3'h5,
		FBM_OP_BUF_CONFIRM = 3'h6,
		FBM_OP_RESET = 3'h7
	} fbm_op_t;

	typedef struct packed {
		fbm_op_t op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fbm_cmd_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic rst_n;
		logic wp_level;
		logic hv_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic dq_oe_n;
	} fbm_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fbm_wcyc_t;
endpackage

// ===== dv/fbm_host_checker.sv
module fbm_host_checker (
	input wire logic clk_i, // clock
	input wire logic nrst_i, // reset
	input wire fbm_pkg::fbm_cmd_t cmd_i, // request
	input wire logic cmd_valid_i, // valid
	input wire logic accel_req_i, // accelerated
	input wire logic busy_i, // busy
	input wire logic cmd_ready_o, // idle
	input wire logic done_o, // done
	input wire logic err_o, // refused
	input wire logic restart_o, // redo
	input wire fbm_pkg::fbm_pins_t pins_o // pins
);
	import fbm_pkg::*;
	logic tk;
	assign tk = cmd_valid_i && cmd_ready_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	property p_rd; !pins_o.ce_n && !pins_o.oe_n |-> pins_o.we_n; endproperty
	a_rd: assert property (p_rd) else $error("read with strobe low");
	property p_wr; !pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n; endproperty
	a_wr: assert property (p_wr) else $error("write with gate low");
	property p_hv; $rose(pins_o.hv_en) |-> $past(tk && cmd_i.op == FBM_OP_PROG && accel_req_i); endproperty
	a_hv: assert property (p_hv) else $error("high voltage outside program");
	property p_acc; tk && cmd_i.op == FBM_OP_PROG && accel_req_i |=> pins_o.hv_en [*5] ##1 done_o; endproperty
	a_acc: assert property (p_acc) else $error("fast program length");
	property p_big; tk && cmd_i.op == FBM_OP_BUF_BEGIN && cmd_i.data >= 16'h0010 |=> err_o; endproperty
	a_big: assert property (p_big) else $error("oversize buffer taken");
	property p_rst; tk && cmd_i.op == FBM_OP_RESET |=> !pins_o.rst_n [*5] ##1 pins_o.rst_n [*2] ##1 done_o; endproperty
	a_rst: assert property (p_rst) else $error("reset pulse shape");
	property p_rsf; tk && cmd_i.op == FBM_OP_RESET && busy_i |-> ##8 restart_o; endproperty
	a_rsf: assert property (p_rsf) else $error("restart flag missing");
	property p_rdl; tk && cmd_i.op == FBM_OP_READ |=> (!pins_o.ce_n && !pins_o.oe_n) [*2] ##1 done_o; endproperty
	a_rdl: assert property (p_rdl) else $error("read access too short");
	c_acc: cover property (tk && cmd_i.op == FBM_OP_PROG && accel_req_i);
	c_err: cover property (err_o);
	c_rsf: cover property (restart_o);
endmodule
bind fbm_host fbm_host_checker fbm_host_checker_i (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd_i),
	.cmd_valid_i(cmd_valid_i), .accel_req_i(accel_req_i), .busy_i(busy_i), .cmd_ready_o(cmd_ready_o),
	.done_o(done_o), .err_o(err_o), .restart_o(restart_o), .pins_o(pins_o));

// ===== dv/fbm_flash_model.sv
module fbm_flash_model (
	input wire fbm_pkg::fbm_pins_t pins_i, // host pins
	output logic [fbm_pkg::DATA_W-1:0] dq_o, // data wire level
	output logic busy_o // programming
);
	timeunit 1ns;
	timeprecision 1ns;
	import fbm_pkg::*;
	localparam logic [15:0] ID_CODE = 16'h5ac3; // arbitrary
	logic [15:0] mem [logic [24:0]];
	logic id_ff, drv;
	logic [15:0] last, d;
	logic [24:0] a;
	int st, left;
	initial begin
		busy_o = 0;
		id_ff = 0;
		st = 0;
		last = 0;
	end
	function automatic logic [15:0] rd(input logic [24:0] x);
		return mem.exists(x) ? mem[x] : 16'hffff;
	endfunction
	// sector zero locked while protect is low unless high voltage lifts it
	task automatic prog();
		if (pins_i.wp_level || pins_i.hv_en || a[24:16] != 0) mem[a] = rd(a) & d;
		busy_o = 1;
	endtask
	always @(negedge pins_i.we_n) if (!pins_i.ce_n && pins_i.rst_n) begin
		a = pins_i.addr;
		d = pins_i.dq_out;
		case (st)
			0: st = (pins_i.hv_en && d == 16'h0003) ? 3 : (a[15:0] == 16'h0001 && d == 16'h0001) ? 1 : 0;
			1: st = (a[15:0] == 16'h0002 && d == 16'h0002) ? 2 : 0;
			2: begin
				if (d == 16'h0004) id_ff = 1;
				st = (d == 16'h0003) ? 3 : (d == 16'h0005) ? 4 : 0;
			end
			3: begin
				prog();
				st = 0;
			end
			4: begin
				left = d + 1;
				st = (left > BUF_MAX_WORDS) ? 0 : 5;
			end
			// words land at load time; simpler than holding them to confirm
			5: begin
				prog();
				left--;
				if (left == 0) st = 6;
			end
			default: st = 0;
		endcase
	end
	always @(negedge pins_i.rst_n) begin
		st = 0;
		id_ff = 0;
		busy_o = 0;
	end
	// keeps running whatever the select does
	always @(posedge busy_o) #3000 busy_o = 0;
	always @* begin
		drv = pins_i.rst_n && !pins_i.ce_n && !pins_i.oe_n;
		if (!pins_i.dq_oe_n) dq_o = pins_i.dq_out;
		else if (drv) dq_o = id_ff ? (ID_CODE & ID_BYTE_MASK) : rd(pins_i.addr);
		else dq_o = ~last;
	end
	always @(dq_o) if (drv || !pins_i.dq_oe_n) last = dq_o;
endmodule

// ===== dv/test_fbm_host.sv
module test_fbm_host;
	timeunit 1ns;
	timeprecision 1ns;
	import fbm_pkg::*;
	logic clk_i = 0, nrst_i = 0, cmd_valid_i = 0, accel_req_i = 0, protect_i = 0, busy, er;
	logic cmd_ready_o, done_o, err_o, id_mode_o, restart_o;
	fbm_cmd_t cmd_i = '0;
	logic [15:0] dq, rd_data_o;
	logic [SECT_W-1:0] sector_o;
	fbm_pins_t pins_o;
	int fail_count = 0, comparisons = 0, lat;
	always #50 clk_i = ~clk_i;
	fbm_host fbm_host_i (.clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i),
		.accel_req_i(accel_req_i), .protect_i(protect_i), .busy_i(busy), .dq_i(dq), .cmd_ready_o(cmd_ready_o),
		.done_o(done_o), .err_o(err_o), .rd_data_o(rd_data_o), .id_mode_o(id_mode_o),
		.restart_o(restart_o), .sector_o(sector_o), .pins_o(pins_o));
	fbm_flash_model fbm_flash_model_i (.pins_i(pins_o), .dq_o(dq), .busy_o(busy));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t ns saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic req(input fbm_op_t op, input logic [24:0] ad, input logic [15:0] dt, input logic acc);
		int k;
		k = 0;
		while (cmd_ready_o !== 1'b1 && k < 40) begin
			@(negedge clk_i);
			k++;
		end
		cmd_i = '{op, ad, dt};
		accel_req_i = acc;
		cmd_valid_i = 1;
		@(negedge clk_i);
		cmd_valid_i = 0;
		lat = 0;
		while (done_o !== 1'b1 && err_o !== 1'b1 && k < 40) begin
			@(negedge clk_i);
			k++;
			lat++;
		end
		er = err_o;
		if (k >= 40) begin
			fail_count++;
			test_done();
		end
		@(negedge clk_i);
	endtask
	task automatic t_prog();
		req(FBM_OP_PROG, 25'h0123456, 16'h3c5a, 0);
		chk(lat, 1 + 4 * (WE_LOW_CYC + WE_HIGH_CYC));
		req(FBM_OP_READ, 25'h0123456, 16'h0, 0);
		chk(lat, ACCESS_CYC);
		chk(rd_data_o, 16'h3c5a);
		chk(sector_o, 9'h012);
		$display("program test over");
	endtask
	task automatic t_accel();
		protect_i = 1;
		req(FBM_OP_PROG, 25'h0000010, 16'h00f0, 1);
		chk(lat, 1 + 2 * (WE_LOW_CYC + WE_HIGH_CYC));
		req(FBM_OP_PROG, 25'h0000011, 16'h0000, 0);
		chk(pins_o.hv_en, 1'b0);
		req(FBM_OP_READ, 25'h0000010, 16'h0, 0);
		chk(rd_data_o, 16'h00f0);
		req(FBM_OP_READ, 25'h0000011, 16'h0, 0);
		chk(rd_data_o, 16'hffff);
		protect_i = 0;
		$display("accelerated test over");
	endtask
	task automatic t_id_reset();
		req(FBM_OP_ID_ENTER, 25'h0, 16'h0, 0);
		chk(lat, 1 + 3 * (WE_LOW_CYC + WE_HIGH_CYC));
		req(FBM_OP_READ, 25'h0000001, 16'h0, 0);
		chk(rd_data_o, 16'h00c3);
		req(FBM_OP_PROG, 25'h0000200, 16'h1234, 0);
		req(FBM_OP_RESET, 25'h0, 16'h0, 0);
		chk(lat, MIN_RESET_PULSE_CYC + RESET_RECOVER_CYC);
		chk(restart_o, 1'b1);
		chk(id_mode_o, 1'b0);
		req(FBM_OP_READ, 25'h0123456, 16'h0, 0);
		chk(rd_data_o, 16'h3c5a);
		req(FBM_OP_PROG, 25'h0000200, 16'h1234, 0);
		chk(restart_o, 1'b0);
		$display("identify and reset test over");
	endtask
	task automatic t_buf();
		req(FBM_OP_BUF_BEGIN, 25'h0040000, 16'h0010, 0);
		chk(er, 1'b1);
		req(FBM_OP_BUF_BEGIN, 25'h0040000, 16'h000f, 0);
		for (int i = 0; i < 16; i++) req(FBM_OP_BUF_WORD, 25'h0040000 + 25'(i), 16'h0a00 + 16'(i), 0);
		chk(er, 1'b0);
		req(FBM_OP_BUF_WORD, 25'h0040010, 16'h0, 0);
		chk(er, 1'b1);
		req(FBM_OP_BUF_CONFIRM, 25'h0040000, 16'h0, 0);
		req(FBM_OP_READ, 25'h004000f, 16'h0, 0);
		chk(rd_data_o, 16'h0a0f);
		$display("buffer test over");
	endtask
	initial begin
		repeat (12) @(negedge clk_i);
		nrst_i = 1;
		t_prog();
		t_accel();
		t_id_reset();
		t_buf();
		test_done();
	end
endmodule
